// ### logic/pets_defs.svh
// offsets, field positions and reset values for the event-trigger selector
// How it works
// R01: select bit 15 enables the conversion-B pulse.
// R02: select bits 14-12 pick the conversion-B event source.
// R03: select bit 11 enables the conversion-A pulse.
// R04: select bits 10-8 pick the conversion-A event source.
// R05: select bit 3 enables the interrupt request.
// R06: select bits 2-0 pick the interrupt event source.
// R07: code 001 means counter equals zero.
// R08: code 010 means counter equals period.
// R09: codes 100/101 mean compare-A match counting up/down.
// R10: codes 110/111 mean compare-B match counting up/down.
// R11: prescale bits 15-14 show conversion-B events seen, zero to three.
// R12: prescale bits 13-12 set conversion-B events needed per pulse.
// R13: conversion-B pulse only while its enable bit is one.
// R14: a pending status flag never holds back a new pulse.
// R15: issuing the conversion-B pulse clears its event counter.
// R16: period 00 disables the path; 01..11 fire on event one to three.
// R17: conversion-A path alike: counter bits 11-10, period bits 9-8.
// R18: codes 000 and 011 produce no event anywhere.
// R19: event counters saturate at three until cleared by a pulse.
`ifndef PETS_DEFS_SVH
`define PETS_DEFS_SVH
`define PETS_ADDR_SELECT 4'h0
`define PETS_ADDR_PRESCALE 4'h1
`define PETS_ADDR_FLAGS 4'h2
`define PETS_ADDR_MASK 4'h3
`define PETS_SEL_B_EN 15
`define PETS_SEL_B_SRC_HI 14
`define PETS_SEL_B_SRC_LO 12
`define PETS_SEL_A_EN 11
`define PETS_SEL_A_SRC_HI 10
`define PETS_SEL_A_SRC_LO 8
`define PETS_SEL_I_EN 3
`define PETS_SEL_I_SRC_HI 2
`define PETS_SEL_I_SRC_LO 0
`define PETS_PS_B_CNT_HI 15
`define PETS_PS_B_CNT_LO 14
`define PETS_PS_B_PRD_HI 13
`define PETS_PS_B_PRD_LO 12
`define PETS_PS_A_CNT_HI 11
`define PETS_PS_A_CNT_LO 10
`define PETS_PS_A_PRD_HI 9
`define PETS_PS_A_PRD_LO 8
`define PETS_SEL_RW_MASK 16'hFF0F
`define PETS_SEL_RESET 16'h0000
`define PETS_PRD_RESET 2'h0
`define PETS_FLAG_RESET 3'h0
`define PETS_CNT_MAX 2'h3
`endif

// ### logic/pets_pkg.sv
// types shared by the event-trigger selector
package pets_pkg;
   typedef logic [2:0] pets_src_type;
   typedef enum logic [2:0] {
      PETS_EV_NONE0 = 3'h0,
      PETS_EV_ZERO = 3'h1,
      PETS_EV_PERIOD = 3'h2,
      PETS_EV_NONE3 = 3'h3,
      PETS_EV_COMPARE_A_VALUE_UP = 3'h4,
      PETS_EV_COMPARE_A_VALUE_DN = 3'h5,
      PETS_EV_COMPARE_B_VALUE_UP = 3'h6,
      PETS_EV_COMPARE_B_VALUE_DN = 3'h7
   } pets_event_type;
   typedef enum logic [2:0] {
      PETS_ST_IDLE = 3'b001,
      PETS_ST_COUNT = 3'b010,
      PETS_ST_FULL = 3'b100
   } pets_state_type;
endpackage : pets_pkg

// ### logic/pets_match_if.sv
// time-base match conditions passed to the selector paths
`timescale 1ns/1ps
interface pets_match_if;
   logic atZero;
   logic atPeriod;
   logic atCmpA;
   logic atCmpB;
   logic countingUp;
   modport source (output atZero, atPeriod, atCmpA, atCmpB, countingUp);
   modport sink (input atZero, atPeriod, atCmpA, atCmpB, countingUp);
endinterface : pets_match_if

// ### logic/pets_prescale_path.sv
// one conversion trigger path: source pick, event counter, pulse
`timescale 1ns/1ps
`include "pets_defs.svh"
module pets_prescale_path (
   input wire logic clock,
   input wire logic reset_n,
   pets_match_if.sink match,
   input wire logic enable,
   input wire pets_pkg::pets_src_type source,
   input wire logic [1:0] period,
   output logic [1:0] eventCount,
   output logic pulse
);
   import pets_pkg::*;

   function automatic logic pick_event(input pets_src_type code,
         input logic z, input logic p, input logic a, input logic b,
         input logic up);
      unique case (pets_event_type'(code))
         PETS_EV_ZERO: pick_event = z;
         PETS_EV_PERIOD: pick_event = p;
         PETS_EV_COMPARE_A_VALUE_UP: pick_event = a & up;
         PETS_EV_COMPARE_A_VALUE_DN: pick_event = a & ~up;
         PETS_EV_COMPARE_B_VALUE_UP: pick_event = b & up;
         PETS_EV_COMPARE_B_VALUE_DN: pick_event = b & ~up;
         default: pick_event = 1'b0;
      endcase
   endfunction : pick_event

   logic hit;
   logic [1:0] count_q;
   logic [1:0] count_d;
   logic pulse_q;
   logic fire;

   // [R07] [R08] [R09] [R10] [R18]
   assign hit = pick_event(source, match.atZero, match.atPeriod,
      match.atCmpA, match.atCmpB, match.countingUp);
   // [R12] [R16] [R13] [R14]
   // widened so a saturated count of three still reaches the period
   assign fire = enable && (period != 2'h0) && hit
      && (({1'b0, count_q} + 3'h1) >= {1'b0, period});

   always_comb begin
      count_d = count_q;
      if (period == 2'h0) begin
         count_d = count_q;
      end else if (fire) begin
         count_d = 2'h0; // [R15]
      end else if (hit && count_q != `PETS_CNT_MAX) begin
         count_d = count_q + 2'h1; // [R19]
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         count_q <= 2'h0;
      end else begin
         count_q <= count_d;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pulse_q <= 1'b0;
      end else begin
         pulse_q <= fire;
      end
   end

   assign eventCount = count_q;
   assign pulse = pulse_q;

   pulse_clears_a: assert property (@(posedge clock) disable iff (!reset_n)
      pulse_q |-> count_q == 2'h0) // [R15]
      else $error("counter not cleared after pulse");
   no_pulse_off_a: assert property (@(posedge clock) disable iff (!reset_n)
      !$past(enable) |-> !pulse_q) // [R13]
      else $error("pulse while disabled");
   cnt_sat_a: assert property (@(posedge clock) disable iff (!reset_n)
      count_q == 2'h3 && !fire |=> count_q == 2'h3) // [R19]
      else $error("counter wrapped");
endmodule : pets_prescale_path

// ### logic/pets_event_trigger.sv
// event-trigger selector: registers, two conversion paths, interrupt
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "pets_defs.svh"
module pets_event_trigger (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [15:0] time_base_count,
   input wire logic [15:0] time_base_period,
   input wire logic [15:0] compare_a_value,
   input wire logic [15:0] compare_b_value,
   input wire logic countingUp,
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [15:0] regRdata,
   output logic conv_a_trigger_pulse,
   output logic conv_b_trigger_pulse,
   output logic module_event_irq
);
   import pets_pkg::*;

   pets_match_if match ();
   logic [15:0] select_q;
   logic [1:0] prdA_q;
   logic [1:0] prdB_q;
   logic [1:0] cntA;
   logic [1:0] cntB;
   logic pulseA;
   logic pulseB;
   logic irqHit;
   logic irqEvent_q;
   logic [2:0] flags_q;
   logic [2:0] mask_q;
   logic [15:0] rdata_q;
   logic wrSel;
   logic wrPs;
   logic wrFlag;
   logic wrMask;

   assign match.atZero = (time_base_count == 16'h0000); // [R07]
   assign match.atPeriod = (time_base_count == time_base_period); // [R08]
   assign match.atCmpA = (time_base_count == compare_a_value); // [R09]
   assign match.atCmpB = (time_base_count == compare_b_value); // [R10]
   assign match.countingUp = countingUp;

   assign wrSel = regWrite && regAddr == `PETS_ADDR_SELECT;
   assign wrPs = regWrite && regAddr == `PETS_ADDR_PRESCALE;
   assign wrFlag = regWrite && regAddr == `PETS_ADDR_FLAGS;
   assign wrMask = regWrite && regAddr == `PETS_ADDR_MASK;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         select_q <= `PETS_SEL_RESET;
      end else if (wrSel) begin
         select_q <= regWdata & `PETS_SEL_RW_MASK;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         prdA_q <= `PETS_PRD_RESET;
         prdB_q <= `PETS_PRD_RESET;
      end else if (wrPs) begin
         prdB_q <= regWdata[`PETS_PS_B_PRD_HI:`PETS_PS_B_PRD_LO]; // [R12]
         prdA_q <= regWdata[`PETS_PS_A_PRD_HI:`PETS_PS_A_PRD_LO]; // [R17]
      end
   end

   pets_prescale_path pathA (
      .clock(clock),
      .reset_n(reset_n),
      .match(match),
      .enable(select_q[`PETS_SEL_A_EN]), // [R03]
      .source(select_q[`PETS_SEL_A_SRC_HI:`PETS_SEL_A_SRC_LO]), // [R04]
      .period(prdA_q), // [R17]
      .eventCount(cntA),
      .pulse(pulseA)
   );

   pets_prescale_path pathB (
      .clock(clock),
      .reset_n(reset_n),
      .match(match),
      .enable(select_q[`PETS_SEL_B_EN]), // [R01]
      .source(select_q[`PETS_SEL_B_SRC_HI:`PETS_SEL_B_SRC_LO]), // [R02]
      .period(prdB_q), // [R16]
      .eventCount(cntB),
      .pulse(pulseB)
   );

   assign conv_a_trigger_pulse = pulseA;
   assign conv_b_trigger_pulse = pulseB;

   // interrupt source: shared decode, gated by enable bit
   always_comb begin
      unique case (pets_event_type'(select_q[`PETS_SEL_I_SRC_HI:
            `PETS_SEL_I_SRC_LO])) // [R06] [R18]
         PETS_EV_ZERO: irqHit = match.atZero;
         PETS_EV_PERIOD: irqHit = match.atPeriod;
         PETS_EV_COMPARE_A_VALUE_UP: irqHit = match.atCmpA & countingUp;
         PETS_EV_COMPARE_A_VALUE_DN: irqHit = match.atCmpA & ~countingUp;
         PETS_EV_COMPARE_B_VALUE_UP: irqHit = match.atCmpB & countingUp;
         PETS_EV_COMPARE_B_VALUE_DN: irqHit = match.atCmpB & ~countingUp;
         default: irqHit = 1'b0;
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         irqEvent_q <= 1'b0;
      end else begin
         irqEvent_q <= irqHit && select_q[`PETS_SEL_I_EN]; // [R05]
      end
   end

   // sticky flags: bit0 interrupt event, bit1 conv A, bit2 conv B
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         flags_q <= `PETS_FLAG_RESET;
      end else begin
         flags_q <= (flags_q & ~(wrFlag ? regWdata[2:0] : 3'h0))
            | {pulseB, pulseA, irqEvent_q};
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         mask_q <= `PETS_FLAG_RESET;
      end else if (wrMask) begin
         mask_q <= regWdata[2:0];
      end
   end

   assign module_event_irq = |(flags_q & mask_q);

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= 16'h0000;
      end else if (regRead) begin
         unique case (regAddr)
            `PETS_ADDR_SELECT: rdata_q <= select_q;
            `PETS_ADDR_PRESCALE: rdata_q <= {cntB, prdB_q, cntA, prdA_q,
               8'h00}; // [R11] [R17]
            `PETS_ADDR_FLAGS: rdata_q <= {13'h0000, flags_q};
            `PETS_ADDR_MASK: rdata_q <= {13'h0000, mask_q};
            default: rdata_q <= 16'h0000;
         endcase
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   assign regRdata = rdata_q;

   irq_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
      irqEvent_q |-> $past(select_q[3])) // [R05]
      else $error("irq event while disabled");
   flag_set_a: assert property (@(posedge clock) disable iff (!reset_n)
      pulseB |=> flags_q[2]) // [R14]
      else $error("pulse flag not set");
   rsvd_none_a: assert property (@(posedge clock) disable iff (!reset_n)
      (select_q[2:0] == 3'h0 || select_q[2:0] == 3'h3) |=> !irqEvent_q)
      // [R18]
      else $error("reserved code raised event");
   read_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
      !regRead |=> regRdata == 16'h0000)
      else $error("read data outside read slot");
   zero_evt_a: assert property (@(posedge clock) disable iff (!reset_n)
      select_q[3:0] == 4'h9 && time_base_count == 16'h0000 |=> irqEvent_q)
      // [R07]
      else $error("zero event missed");

   // enabled interrupt source hit, then the registered event one edge later
   sequence irq_event_seq;
      irqHit && select_q[`PETS_SEL_I_EN] ##1 irqEvent_q;
   endsequence

   irq_flag_a: assert property (@(posedge clock) disable iff (!reset_n)
      irq_event_seq |=> flags_q[0]) // [R05]
      else $error("irq flag not set");
   flag_a_set_a: assert property (@(posedge clock) disable iff (!reset_n)
      pulseA |=> flags_q[1]) // [R17]
      else $error("conv A flag not set");
endmodule : pets_event_trigger

// ### verif/pets_conv_sink.sv
// far-side model: converter sequencer counting trigger pulses
`timescale 1ns/1ps
module pets_conv_sink (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic convA,
   input wire logic convB,
   output logic [7:0] countA,
   output logic [7:0] countB
);
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         countA <= 8'h00;
         countB <= 8'h00;
      end else begin
         countA <= countA + {7'h00, convA};
         countB <= countB + {7'h00, convB};
      end
   end
endmodule : pets_conv_sink

// ### verif/pwm_event_trigger_select_tb.sv
// self-checking bench for the event-trigger selector
`timescale 1ns/1ps
`include "pets_defs.svh"
module pwm_event_trigger_select_tb;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic [15:0] tbCount = 16'h0005;
   logic up = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic [15:0] got;
   logic pulseA, pulseB, irq;
   logic [7:0] cntA, cntB;
   int error_cnt = 0;
   int comparisons = 0;
   always #12.5 clock = ~clock;
   pets_event_trigger dut (.clock(clock), .reset_n(reset_n),
      .time_base_count(tbCount), .time_base_period(16'h0100),
      .compare_a_value(16'h0020), .compare_b_value(16'h0030),
      .countingUp(up), .regAddr(addr), .regWdata(wdata),
      .regWrite(wr), .regRead(rd), .regRdata(rdata),
      .conv_a_trigger_pulse(pulseA), .conv_b_trigger_pulse(pulseB),
      .module_event_irq(irq));
   pets_conv_sink sink (.clock(clock), .reset_n(reset_n),
      .convA(pulseA), .convB(pulseB), .countA(cntA), .countB(cntB));
   task automatic complete_run;
      $display("counts: %0d compares, %0d mismatches", comparisons,
         error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wrReg(input logic [3:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      @(posedge clock);
   endtask : wrReg
   task automatic rdReg(input logic [3:0] a);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(posedge clock);
      got = rdata;
   endtask : rdReg
   // one-cycle time-base match of kind e, then idle
   task automatic evChk(input int e, input logic [7:0] expA,
         input logic [7:0] expB, input logic expI);
      logic [7:0] a0, b0;
      a0 = cntA;
      b0 = cntB;
      case (e)
         1: tbCount <= 16'h0000;
         2: tbCount <= 16'h0100;
         4, 5: tbCount <= 16'h0020;
         default: tbCount <= 16'h0030;
      endcase
      up <= (e % 2 == 0);
      @(posedge clock);
      tbCount <= 16'h0005;
      repeat (3) @(posedge clock);
      check({8'h00, cntA - a0}, {8'h00, expA});
      check({8'h00, cntB - b0}, {8'h00, expB});
      check({15'h0000, irq}, {15'h0000, expI});
   endtask : evChk
   initial begin
      #1000000;
      error_cnt++;
      complete_run();
   end
   initial begin
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      rdReg(`PETS_ADDR_SELECT);
      check(got, `PETS_SEL_RESET);
      rdReg(`PETS_ADDR_PRESCALE);
      check(got, 16'h0000);
      wrReg(`PETS_ADDR_SELECT, 16'hFFFF);
      rdReg(`PETS_ADDR_SELECT);
      check(got, `PETS_SEL_RW_MASK);
      rdReg(4'h5);
      check(got, 16'h0000);
      $display("done: registers");
      wrReg(`PETS_ADDR_MASK, 16'h0001);
      wrReg(`PETS_ADDR_PRESCALE, 16'h1101);
      for (int c = 0; c < 8; c++) begin
         wrReg(`PETS_ADDR_SELECT, 16'h8808 | 16'(c * 16'h1101));
         for (int e = 1; e < 8; e++) begin
            if (e != 3) begin
               evChk(e, 8'(c == e), 8'(c == e), c == e);
               wrReg(`PETS_ADDR_FLAGS, 16'h0007);
            end
         end
      end
      $display("done: sources");
      wrReg(`PETS_ADDR_SELECT, 16'h9000);
      wrReg(`PETS_ADDR_PRESCALE, 16'h2000);
      evChk(1, 8'h00, 8'h00, 1'b0);
      rdReg(`PETS_ADDR_PRESCALE);
      check(got, 16'h6000);
      evChk(1, 8'h00, 8'h01, 1'b0);
      rdReg(`PETS_ADDR_PRESCALE);
      check(got, 16'h2000);
      wrReg(`PETS_ADDR_PRESCALE, 16'h3000);
      for (int k = 1; k < 4; k++)
         evChk(1, 8'h00, 8'(k == 3), 1'b0);
      wrReg(`PETS_ADDR_PRESCALE, 16'h0000);
      evChk(1, 8'h00, 8'h00, 1'b0);
      rdReg(`PETS_ADDR_PRESCALE);
      check(got, 16'h0000);
      wrReg(`PETS_ADDR_SELECT, 16'h1000);
      wrReg(`PETS_ADDR_PRESCALE, 16'h1000);
      for (int k = 0; k < 4; k++)
         evChk(1, 8'h00, 8'h00, 1'b0);
      rdReg(`PETS_ADDR_PRESCALE);
      check(got, 16'hD000);
      rdReg(`PETS_ADDR_FLAGS);
      check(got, 16'h0004);
      wrReg(`PETS_ADDR_SELECT, 16'h9000);
      evChk(1, 8'h00, 8'h01, 1'b0);
      rdReg(`PETS_ADDR_PRESCALE);
      check(got, 16'h1000);
      $display("done: conversion B prescale");
      wrReg(`PETS_ADDR_SELECT, 16'h0900);
      wrReg(`PETS_ADDR_PRESCALE, 16'h0200);
      evChk(1, 8'h00, 8'h00, 1'b0);
      rdReg(`PETS_ADDR_PRESCALE);
      check(got, 16'h0600);
      evChk(1, 8'h01, 8'h00, 1'b0);
      $display("done: conversion A prescale");
      wrReg(`PETS_ADDR_FLAGS, 16'h0007);
      wrReg(`PETS_ADDR_SELECT, 16'h0001);
      evChk(1, 8'h00, 8'h00, 1'b0);
      wrReg(`PETS_ADDR_SELECT, 16'h0009);
      wrReg(`PETS_ADDR_MASK, 16'h0000);
      evChk(1, 8'h00, 8'h00, 1'b0);
      rdReg(`PETS_ADDR_FLAGS);
      check(got, 16'h0001);
      wrReg(`PETS_ADDR_MASK, 16'h0001);
      check({15'h0000, irq}, 16'h0001);
      wrReg(`PETS_ADDR_FLAGS, 16'h0001);
      check({15'h0000, irq}, 16'h0000);
      $display("done: interrupt");
      complete_run();
   end
endmodule : pwm_event_trigger_select_tb
